// [verilog/serial_memory_write_commands.sv]
// serial memory write command interpreter, link side on sck, commit side on ref_clk
`timescale 1ns/1ps
`include "mem_write_map.svh"
module serial_memory_write_commands (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        sck,
  input  wire logic                        cs_n,
  input  wire logic [3:0]                  io_in,
  input  wire mem_write_pkg::line_proto_e  line_proto,
  input  wire logic                        write_latch_flag,
  input  wire logic                        blk_protected,
  output logic                             mem_we,
  output logic [`ADDR_MSB:0]               mem_addr,
  output logic [7:0]                       mem_wdata,
  output logic                             xip_active
);
  import mem_write_pkg::*;

  function automatic logic [2:0] proto_lanes(input line_proto_e p);
    logic [2:0] l;
    l = `LANES_1;
    unique case (p)
      single_line_protocol: l = `LANES_1;
      two_line_protocol:    l = `LANES_2;
      four_line_protocol:   l = `LANES_4;
      default:              l = `LANES_1;
    endcase
    return l;
  endfunction

  function automatic cmd_s cmd_info(input logic [7:0] op, input line_proto_e p);
    cmd_s c;
    logic spi;
    spi = (p == single_line_protocol);
    c = '{legal: 1'b0, has_mode: 1'b0, ddr: 1'b0, addr_w: `LANES_1, data_w: `LANES_1};
    unique case (op)
      `BASIC_WRITE_CMD:
        c = '{1'b1, 1'b0, 1'b0, proto_lanes(p), proto_lanes(p)};
      `MODE_WRITE_CMD:
        c = '{1'b1, 1'b1, 1'b0, proto_lanes(p), proto_lanes(p)};
      `DOUBLE_RATE_WRITE_CMD:
        c = '{p == four_line_protocol, 1'b0, 1'b1, `LANES_4, `LANES_4};
      `DOUBLE_RATE_MODE_WRITE_CMD:
        c = '{p == four_line_protocol, 1'b1, 1'b1, `LANES_4, `LANES_4};
      `TWO_LINE_DATA_WRITE_CMD:
        c = '{spi, 1'b1, 1'b0, `LANES_1, `LANES_2};
      `TWO_LINE_ADDR_DATA_WRITE_CMD:
        c = '{spi, 1'b1, 1'b0, `LANES_2, `LANES_2};
      `FOUR_LINE_DATA_WRITE_CMD:
        c = '{spi, 1'b1, 1'b0, `LANES_1, `LANES_4};
      `FOUR_LINE_ADDR_DATA_WRITE_CMD:
        c = '{spi, 1'b1, 1'b0, `LANES_4, `LANES_4};
      `DOUBLE_RATE_FOUR_LINE_WRITE_CMD:
        c = '{spi, 1'b1, 1'b1, `LANES_4, `LANES_4};
      default:
        c = '{1'b0, 1'b0, 1'b0, `LANES_1, `LANES_1};
    endcase
    return c;
  endfunction

  // io1 carries the more significant bit, io3 the most in four-line transfers
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic [3:0] io,
                                          input logic [2:0] lanes);
    logic [7:0] r;
    r = {sr[6:0], io[0]};
    if (lanes == `LANES_2)
      r = {sr[5:0], io[1:0]};
    else if (lanes == `LANES_4)
      r = {sr[3:0], io[3:0]};
    return r;
  endfunction

  // ref_clk side state
  cfg_s                cfg_r;
  logic                xip_r;
  logic [7:0]          xip_op_r;
  logic                cs_s1_r;
  logic                cs_s2_r;
  logic                tp_s1_r;
  logic                tp_s2_r;
  logic                tp_s3_r;
  logic                tn_s1_r;
  logic                tn_s2_r;
  logic                tn_s3_r;
  logic                wr_pend_r;
  logic                mem_we_r;
  logic [`ADDR_MSB:0]  mem_addr_r;
  logic [7:0]          mem_wdata_r;

  // sck rising edge state
  phase_e              ph_r;
  phase_e              ph_nxt;
  logic [7:0]          sr_r;
  logic [7:0]          op_r;
  logic [3:0]          cnt_r;
  logic [1:0]          bidx_r;
  logic [15:0]         ahi_r;
  logic [`ADDR_MSB:0]  waddr_r;
  logic [3:0]          hi_r;
  byte_kind_e          kind_r;
  logic                last_addr_r;
  pkt_s                pk_r;
  logic                tog_p_r;

  // sck falling edge state
  logic [7:0]          nb_r;
  pkt_s                npk_r;
  logic                tog_n_r;

  // link side decode
  logic                at_start;
  phase_e              cur_ph;
  logic [7:0]          cur_op;
  cmd_s                info;
  cmd_s                new_info;
  logic                run;
  logic [2:0]          lanes;
  logic                ddr_ph;
  logic [7:0]          sr_nxt;
  logic [3:0]          cnt_sum;
  logic                byte_done;
  logic                addr_step;
  logic                ddr_take;
  logic [7:0]          addr_byte;
  logic [`ADDR_MSB:0]  addr_full;
  logic                addr_last;
  byte_kind_e          kind_nxt;
  logic                sdr_emit;

  // an opcode-skip frame starts straight with the address of the remembered command
  assign at_start  = (ph_r == ph_start);
  assign cur_ph    = at_start ? (cfg_r.opcode_skip_mode ? ph_addr : ph_op) : ph_r;
  assign cur_op    = at_start ? cfg_r.xip_op : op_r;
  assign info      = cmd_info(cur_op, cfg_r.proto);
  assign run       = !(at_start && cfg_r.opcode_skip_mode && !info.legal);
  assign lanes     = (cur_ph == ph_op)   ? proto_lanes(cfg_r.proto) :
                     (cur_ph == ph_data) ? info.data_w : info.addr_w;
  assign ddr_ph    = info.ddr && (cur_ph == ph_addr || cur_ph == ph_mode ||
                                  cur_ph == ph_data);
  assign sr_nxt    = shift_in(sr_r, io_in, lanes);
  assign cnt_sum   = cnt_r + {1'b0, lanes};
  assign byte_done = run && !ddr_ph && (cnt_sum == `BYTE_BITS);
  assign new_info  = cmd_info(sr_nxt, cfg_r.proto);
  assign addr_step = run && (ddr_ph || byte_done);
  assign ddr_take  = (kind_r == k_addr);
  assign addr_byte = ddr_take ? nb_r : sr_nxt;
  assign addr_full = {ahi_r[12:0], addr_byte};
  assign addr_last = ddr_take ? last_addr_r : (bidx_r == `LAST_ADDR_BYTE);
  assign sdr_emit  = byte_done && (cur_ph == ph_mode || cur_ph == ph_data);
  assign kind_nxt  = !(run && ddr_ph)   ? k_none :
                     (cur_ph == ph_addr) ? k_addr :
                     (cur_ph == ph_mode) ? k_mode : k_data;

  always_comb
  begin
    ph_nxt = cur_ph;
    unique case (cur_ph)
      ph_op:
        if (byte_done)
          ph_nxt = new_info.legal ? ph_addr : ph_skip;
      ph_addr:
        if (addr_step && bidx_r == `LAST_ADDR_BYTE)
          ph_nxt = info.has_mode ? ph_mode : ph_data;
      ph_mode:
        if (addr_step)
          ph_nxt = ph_data;
      ph_data:  ph_nxt = ph_data;
      ph_skip:  ph_nxt = ph_skip;
      default:  ph_nxt = ph_skip;
    endcase
    if (!run)
      ph_nxt = ph_skip;
  end

  // frame state is cleared by chip select itself, since sck stops between frames
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      ph_r        <= ph_start;
      sr_r        <= 8'h00;
      op_r        <= 8'h00;
      cnt_r       <= 4'h0;
      bidx_r      <= 2'h0;
      ahi_r       <= 16'h0000;
      waddr_r     <= '0;
      hi_r        <= 4'h0;
      kind_r      <= k_none;
      last_addr_r <= 1'b0;
      pk_r        <= '0;
      tog_p_r     <= 1'b0;
    end
    else
    begin
      ph_r   <= ph_nxt;
      hi_r   <= io_in;
      kind_r <= kind_nxt;
      sr_r   <= sr_nxt;
      cnt_r  <= (ddr_ph || byte_done) ? 4'h0 : cnt_sum;
      if (at_start)
        op_r <= cfg_r.xip_op;
      if (cur_ph == ph_op && byte_done)
        op_r <= sr_nxt;
      if (cur_ph == ph_addr && addr_step)
      begin
        bidx_r      <= bidx_r + 2'h1;
        last_addr_r <= (bidx_r == `LAST_ADDR_BYTE);
      end
      if ((!ddr_ph && cur_ph == ph_addr && byte_done) || ddr_take)
      begin
        ahi_r <= {ahi_r[7:0], addr_byte};
        if (addr_last)
          waddr_r <= addr_full;
      end
      else if ((kind_r == k_data) || (byte_done && cur_ph == ph_data))
        waddr_r <= waddr_r + 21'h000001;
      if (sdr_emit)
      begin
        pk_r    <= '{(cur_ph == ph_mode) ? k_mode : k_data, cur_op, waddr_r, sr_nxt};
        tog_p_r <= ~tog_p_r;
      end
    end
  end

  // double-rate bytes complete on the falling edge; clock mode zero assumed
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      nb_r    <= 8'h00;
      npk_r   <= '0;
      tog_n_r <= 1'b0;
    end
    else
    begin
      nb_r <= {hi_r, io_in};
      if (kind_r == k_mode || kind_r == k_data)
      begin
        npk_r   <= '{kind_r, op_r, waddr_r, {hi_r, io_in}};
        tog_n_r <= ~tog_n_r;
      end
    end
  end

  // commit side
  logic  ev_p;
  logic  ev_n;
  logic  ev;
  pkt_s  pkt_w;
  logic  xip_hit;

  // toggles drop back at frame end; the cs mask hides that false edge.
  // packets are read a few ref_clk cycles after they settle, which bounds sck
  assign ev_p    = (tp_s2_r ^ tp_s3_r) && !cs_s2_r;
  assign ev_n    = (tn_s2_r ^ tn_s3_r) && !cs_s2_r;
  assign ev      = ev_p || ev_n;
  assign pkt_w   = ev_p ? pk_r : npk_r;
  assign xip_hit = (pkt_w.op == `DOUBLE_RATE_MODE_WRITE_CMD) ?
                   (pkt_w.data == `OPCODE_SKIP_DDR_MODE) :
                   (pkt_w.data[7:4] == `OPCODE_SKIP_NIBBLE);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cs_s1_r     <= 1'b1;
      cs_s2_r     <= 1'b1;
      tp_s1_r     <= 1'b0;
      tp_s2_r     <= 1'b0;
      tp_s3_r     <= 1'b0;
      tn_s1_r     <= 1'b0;
      tn_s2_r     <= 1'b0;
      tn_s3_r     <= 1'b0;
      cfg_r       <= '{single_line_protocol, 1'b0, 8'h00};
      xip_r       <= 1'b0;
      xip_op_r    <= 8'h00;
      wr_pend_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= '0;
      mem_wdata_r <= 8'h00;
    end
    else
    begin
      cs_s1_r   <= cs_n;
      cs_s2_r   <= cs_s1_r;
      tp_s1_r   <= tog_p_r;
      tp_s2_r   <= tp_s1_r;
      tp_s3_r   <= tp_s2_r;
      tn_s1_r   <= tog_n_r;
      tn_s2_r   <= tn_s1_r;
      tn_s3_r   <= tn_s2_r;
      if (cs_s2_r)
        cfg_r <= '{line_proto, xip_r, xip_op_r};
      wr_pend_r <= 1'b0;
      mem_we_r  <= wr_pend_r && !blk_protected;
      if (ev && pkt_w.kind == k_data)
      begin
        mem_addr_r  <= pkt_w.addr;
        mem_wdata_r <= pkt_w.data;
        wr_pend_r   <= write_latch_flag;
      end
      if (ev && pkt_w.kind == k_mode)
      begin
        xip_r    <= xip_hit;
        xip_op_r <= pkt_w.op;
      end
    end
  end

  assign mem_we     = mem_we_r;
  assign mem_addr   = mem_addr_r;
  assign mem_wdata  = mem_wdata_r;
  assign xip_active = xip_r;
endmodule

// [verilog/mem_write_map.svh]
// constants for the serial memory write command block
`ifndef MEM_WRITE_MAP_SVH
`define MEM_WRITE_MAP_SVH
`define BASIC_WRITE_CMD                 8'h02
`define MODE_WRITE_CMD                  8'hda
`define DOUBLE_RATE_WRITE_CMD           8'hde
`define DOUBLE_RATE_MODE_WRITE_CMD      8'hdd
`define TWO_LINE_DATA_WRITE_CMD         8'ha2
`define TWO_LINE_ADDR_DATA_WRITE_CMD    8'ha1
`define FOUR_LINE_DATA_WRITE_CMD        8'h32
`define FOUR_LINE_ADDR_DATA_WRITE_CMD   8'hd2
`define DOUBLE_RATE_FOUR_LINE_WRITE_CMD 8'hd1
`define OPCODE_SKIP_NIBBLE              4'ha
`define OPCODE_SKIP_DDR_MODE            8'ha5
`define ADDR_MSB                        20
`define BYTE_BITS                       4'h8
`define LAST_ADDR_BYTE                  2'h2
`define LANES_1                         3'h1
`define LANES_2                         3'h2
`define LANES_4                         3'h4
`endif

// [verilog/mem_write_pkg.sv]
// types shared by the serial memory write command block
package mem_write_pkg;
`include "mem_write_map.svh"
  typedef enum logic [1:0] {single_line_protocol, two_line_protocol, four_line_protocol}
    line_proto_e;
  typedef enum logic [1:0] {k_none, k_addr, k_mode, k_data} byte_kind_e;
  typedef enum logic [2:0] {ph_start, ph_op, ph_addr, ph_mode, ph_data, ph_skip} phase_e;
  typedef struct packed {
    logic       legal;
    logic       has_mode;
    logic       ddr;
    logic [2:0] addr_w;
    logic [2:0] data_w;
  } cmd_s;
  typedef struct packed {
    byte_kind_e          kind;
    logic [7:0]          op;
    logic [`ADDR_MSB:0]  addr;
    logic [7:0]          data;
  } pkt_s;
  typedef struct packed {
    line_proto_e proto;
    logic        opcode_skip_mode;
    logic [7:0]  xip_op;
  } cfg_s;
endpackage

// [sim/spi_host_model.sv]
// host controller model driving the serial write link
`timescale 1ns/1ps
module spi_host_model (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // unused lanes flip every half so a stale level never looks valid
  task automatic half(input logic [3:0] b, input int w);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    io_in = (b & m) | (~io_in & ~m);
    #31.25 sck = ~sck;
    #31.25;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w, input bit ddr);
    int i;
    for (i = n - w; i >= 0; i -= w)
    begin
      half(4'(v >> i), w);
      if (!ddr)
        half(4'(v >> i), w);
    end
  endtask
  // address and data lanes per command
  function automatic logic [7:0] lanes(input logic [7:0] op, input int p);
    case (op)
      8'ha2: return 8'h12;
      8'ha1: return 8'h22;
      8'h32: return 8'h14;
      8'hd2, 8'hd1, 8'hde, 8'hdd: return 8'h44;
      default: return {4'(p), 4'(p)};
    endcase
  endfunction
  task automatic frame(input logic [7:0] op, input bit skip, input logic [23:0] a,
                       input logic [7:0] md, input int nb, input int pb, input int p);
    logic [7:0] lw;
    bit         ddr;
    int         k;
    lw = lanes(op, p);
    ddr = op inside {8'hde, 8'hdd, 8'hd1};
    cs_n = 1'b0;
    #31.25;
    if (!skip)
      send(op, 8, p, 1'b0);
    send(a, 24, lw[7:4], ddr);
    if (!(op inside {8'h02, 8'hde}))
      send(md, 8, lw[7:4], ddr);
    for (k = 0; k < nb; k++)
      send(8'h5a + k, 8, lw[3:0], ddr);
    send(0, pb, lw[3:0], 1'b0);
    #100 cs_n = 1'b1;
    #200;
  endtask
endmodule

// [sim/write_cmd_monitor.sv]
// assertion checker for the serial memory write block
`timescale 1ns/1ps
`include "mem_write_map.svh"
module write_cmd_monitor (
  input wire logic               ref_clk,
  input wire logic               srst,
  input wire logic               cs_n,
  input wire logic               write_latch_flag,
  input wire logic               blk_protected,
  input wire logic               mem_we,
  input wire logic [`ADDR_MSB:0] mem_addr,
  input wire logic [7:0]         mem_wdata,
  input wire logic               xip_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [2:0] hi_cnt_r;
  logic [2:0] hi_cnt_nxt;
  logic       new_frame_r;
  // a long chip select high run marks a frame gap seen from this clock
  assign hi_cnt_nxt = cs_n ? (hi_cnt_r == 3'h7 ? hi_cnt_r : hi_cnt_r + 3'h1) : 3'h0;
  always_ff @(posedge ref_clk)
  begin
    hi_cnt_r <= srst ? 3'h0 : hi_cnt_nxt;
    new_frame_r <= srst || hi_cnt_r >= 3'h3 || (new_frame_r && !$changed(mem_addr));
  end
  sequence load_s;
    $changed(mem_addr) && write_latch_flag && !blk_protected;
  endsequence
  reset_state_a: assert property (disable iff (1'b0) srst |=> !mem_we && mem_addr == 0
    && mem_wdata == 0 && !xip_active) else $error("outputs not cleared by reset");
  we_pulse_a: assert property (mem_we |=> !mem_we [*3]) else $error("write pulse too long");
  we_latch_a: assert property (mem_we |-> write_latch_flag)
    else $error("write with latch flag low");
  we_prot_a: assert property (mem_we |-> !blk_protected)
    else $error("write into protected block");
  we_settled_a: assert property (mem_we |-> $stable(mem_addr) && $stable(mem_wdata))
    else $error("write while address or data moving");
  commit_follow_a: assert property (load_s |=> mem_we)
    else $error("loaded byte not committed");
  addr_step_a: assert property ($changed(mem_addr) && !new_frame_r
    |-> mem_addr == 21'($past(mem_addr) + 21'h1)) else $error("address did not step by one");
  we_in_frame_a: assert property (mem_we |-> hi_cnt_r < 3'h3)
    else $error("write outside a frame");
  xip_quiet_a: assert property (hi_cnt_r == 3'h7 |-> $stable(xip_active))
    else $error("skip mode changed between frames");
endmodule
bind serial_memory_write_commands write_cmd_monitor i_mon (.ref_clk, .srst, .cs_n,
  .write_latch_flag, .blk_protected, .mem_we, .mem_addr, .mem_wdata, .xip_active);

// [sim/testbench.sv]
// self-checking bench for the serial memory write block
`timescale 1ns/1ps
`include "mem_write_map.svh"
module testbench;
  import mem_write_pkg::*;
  logic               ref_clk;
  logic               srst;
  logic               sck;
  logic               cs_n;
  logic [3:0]         io_in;
  line_proto_e        line_proto;
  logic               write_latch_flag;
  logic               blk_protected;
  logic               prot_en;
  logic               mem_we;
  logic [`ADDR_MSB:0] mem_addr;
  logic [7:0]         mem_wdata;
  logic               xip_active;
  int                 failures;
  int                 checked;
  logic [28:0]        got [$];
  serial_memory_write_commands i_dut (.ref_clk, .srst, .sck, .cs_n, .io_in, .line_proto,
    .write_latch_flag, .blk_protected, .mem_we, .mem_addr, .mem_wdata, .xip_active);
  spi_host_model i_host (.sck, .cs_n, .io_in);
  // protected block spans 0x100 to 0x1ff
  assign blk_protected = prot_en && mem_addr[20:8] == 13'h001;
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (mem_we === 1'b1)
      got.push_back({mem_addr, mem_wdata});
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic expect_run(input logic [20:0] a, input int n, input int k0);
    int j;
    check(32'(got.size()), 32'(n));
    for (j = 0; j < n && j < got.size(); j++)
      check(32'(got[j]), {3'h0, 21'(a + j), 8'(8'h5a + k0 + j)});
    got.delete();
  endtask
  task automatic use_proto(input line_proto_e p);
    @(posedge ref_clk) line_proto <= p;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic basic_case();
    i_host.frame(8'h02, 1'b0, 24'he00010, 8'h00, 3, 0, 1);
    expect_run(21'h000010, 3, 0);
  endtask
  task automatic wrap_case();
    i_host.frame(8'h02, 1'b0, 24'h1ffffe, 8'h00, 3, 0, 1);
    expect_run(21'h1ffffe, 3, 0);
  endtask
  task automatic latch_case();
    @(posedge ref_clk) write_latch_flag <= 1'b0;
    i_host.frame(8'h02, 1'b0, 24'h000020, 8'h00, 2, 0, 1);
    expect_run(21'h000020, 0, 0);
    @(posedge ref_clk) write_latch_flag <= 1'b1;
  endtask
  task automatic prot_case();
    @(posedge ref_clk) prot_en <= 1'b1;
    i_host.frame(8'h02, 1'b0, 24'h0000fe, 8'h00, 4, 0, 1);
    expect_run(21'h0000fe, 2, 0);
    i_host.frame(8'h02, 1'b0, 24'h0001fe, 8'h00, 4, 0, 1);
    expect_run(21'h000200, 2, 2);
    @(posedge ref_clk) prot_en <= 1'b0;
  endtask
  task automatic partial_case();
    i_host.frame(8'h02, 1'b0, 24'h000040, 8'h00, 1, 5, 1);
    expect_run(21'h000040, 1, 0);
  endtask
  task automatic lane_case();
    logic [7:0] ops [10] = '{8'ha2, 8'ha1, 8'h32, 8'hd2, 8'hd1, 8'h02, 8'h02, 8'hde,
                             8'ha2, 8'hde};
    int         ln [10] = '{1, 1, 1, 1, 1, 2, 4, 4, 4, 1};
    int         n [10] = '{2, 2, 2, 2, 2, 2, 2, 2, 0, 0};
    int         i;
    for (i = 0; i < 10; i++)
    begin
      use_proto(line_proto_e'(ln[i] >> 1));
      i_host.frame(ops[i], 1'b0, 24'(24'h300 + i * 4), 8'h00, 2, 0, ln[i]);
      expect_run(21'(21'h300 + i * 4), n[i], 0);
      check(xip_active, 1'b0);
    end
    use_proto(single_line_protocol);
  endtask
  task automatic skip_case();
    i_host.frame(8'hda, 1'b0, 24'h000500, 8'ha3, 2, 0, 1);
    expect_run(21'h000500, 2, 0);
    check(xip_active, 1'b1);
    i_host.frame(8'hda, 1'b1, 24'h000510, 8'h00, 2, 0, 1);
    expect_run(21'h000510, 2, 0);
    check(xip_active, 1'b0);
    use_proto(four_line_protocol);
    i_host.frame(8'hdd, 1'b0, 24'h000520, 8'ha4, 2, 0, 4);
    expect_run(21'h000520, 2, 0);
    check(xip_active, 1'b0);
    i_host.frame(8'hdd, 1'b0, 24'h000530, 8'ha5, 2, 0, 4);
    check(xip_active, 1'b1);
    expect_run(21'h000530, 2, 0);
    i_host.frame(8'hdd, 1'b1, 24'h000540, 8'h00, 2, 0, 4);
    expect_run(21'h000540, 2, 0);
    check(xip_active, 1'b0);
    use_proto(single_line_protocol);
  endtask
  // skip mode armed before a mid-run reset must not survive it
  task automatic reset_case();
    i_host.frame(8'hda, 1'b0, 24'h000600, 8'ha3, 2, 0, 1);
    expect_run(21'h000600, 2, 0);
    check(xip_active, 1'b1);
    @(posedge ref_clk) srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(xip_active, 1'b0);
    i_host.frame(8'hda, 1'b0, 24'h000610, 8'h00, 2, 0, 1);
    expect_run(21'h000610, 2, 0);
  endtask
  task automatic final_report();
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #500000;
    failures++;
    final_report();
  end
  initial
  begin
    failures = 0;
    checked = 0;
    srst = 1'b1;
    line_proto = single_line_protocol;
    write_latch_flag = 1'b1;
    prot_en = 1'b0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    basic_case();
    wrap_case();
    latch_case();
    prot_case();
    partial_case();
    lane_case();
    skip_case();
    reset_case();
    final_report();
  end
endmodule
